// *** debug_arm_core_model.sv ***
`default_nettype none
// processor side: counts breakpoints, ends a trace session after a delay
module debug_arm_core_model (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire debug_arm_pkg::break_req_s break_req_i,
    input wire logic trace_enable_i,
    input wire logic armed_i,
    output logic trace_done_o,
    output var int bg_count_o,
    output var int swi_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic armed_prev;
    int wait_cnt;
    // every request pulse is counted; a dropped break leaves both counts alone
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            bg_count_o <= 0;
            swi_count_o <= 0;
            wait_cnt <= 0;
            trace_done_o <= 1'b0;
            armed_prev <= 1'b0;
        end else begin
            armed_prev <= armed_i;
            bg_count_o <= bg_count_o + int'(break_req_i.background);
            swi_count_o <= swi_count_o + int'(break_req_i.software_interrupt_request);
            // trace drains slowly, so a held break must wait for it
            if (trace_enable_i && armed_prev && !armed_i) begin
                wait_cnt <= 8;
            end else if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end
            trace_done_o <= (wait_cnt == 1);
        end
    end
endmodule : debug_arm_core_model
`default_nettype wire

// *** debug_arm_pkg.sv ***
`default_nettype none
package debug_arm_pkg;
    // register indices as numbered on the part, byte address is four times the index
    localparam logic [11:0] CTL_ONE_INDEX = 12'h100;
    localparam logic [11:0] CTL_TWO_INDEX = 12'h101;
    localparam logic [11:0] CTL_ONE_ADDR = {CTL_ONE_INDEX[9:0], 2'b00};
    localparam logic [11:0] CTL_TWO_ADDR = {CTL_TWO_INDEX[9:0], 2'b00};
    // field positions of control register one
    localparam int unsigned ARM_POS = 7;
    localparam int unsigned FORCE_POS = 6;
    localparam int unsigned BTB_POS = 4;
    localparam int unsigned PBE_POS = 3;
    // reset values
    localparam logic [7:0] CTL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTL_TWO_RESET = 8'h00;
    // external event modes
    localparam logic [1:0] EES_OFF = 2'h0;
    localparam logic [1:0] EES_TRACE_ENTRY = 2'h1;
    localparam logic [1:0] EES_SEQ_INPUT = 2'h2;
    localparam logic [1:0] EES_GATE = 2'h3;
    // comparator pair mapping modes
    localparam logic [1:0] MAP_SINGLE = 2'h0;
    localparam logic [1:0] MAP_INSIDE = 2'h1;
    localparam logic [1:0] MAP_OUTSIDE = 2'h2;
    localparam logic [1:0] MAP_RESERVED = 2'h3;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_FIRST = 3'h2,
        SEQ_FINAL = 3'h4
    } seq_state_e;

    typedef struct packed {
        logic arm;
        logic break_to_background;
        logic processor_break_enable;
        logic [1:0] external_event_select;
    } ctl_one_s;

    typedef struct packed {
        logic [1:0] upper_pair_match_map;
        logic [1:0] lower_pair_match_map;
    } ctl_two_s;

    // breakpoint requests toward the processor
    typedef struct packed {
        logic background;
        logic software_interrupt_request;
    } break_req_s;
endpackage : debug_arm_pkg
`default_nettype wire

// *** debug_arm_trigger_control.sv ***
// Overview of operation
// - while armed, only arm and force-final bits accept writes
// - arm bit writable anytime, but clearing ignored while profiling active
// - force-final bit writable anytime, always reads zero
// - low six bits of register one update only when disarmed and not profiling
// - hardware disarm beats a simultaneous write, clears arm, breaks if enabled
// - arm clears automatically when sequencer returns to idle
// - setting arm moves sequencer into first active state
// - software disarm produces no breakpoint
// - writing one to force-final together with arm jumps sequencer to final; zero does nothing
// - break routes to background if selected and controller enabled (else dropped), to interrupt if not selected and not background
// - processor break on idle return, deferred until tracing completes if tracing
// - external event select: off, trace entry, channel 3 replacement, trace gate
// - register two writable only disarmed and not profiling, readable anytime
// - upper pair map: single, inside range, outside range; ranges disable channel 3
// - upper pair reserved code acts as inside range
// - lower pair map: single, inside range, outside range; ranges disable channel 1
// - lower pair reserved code acts as inside range
//
// The APB interface to the registers was left to the implementer.
`default_nettype none

// maps one comparator pair onto its two match channels
module pair_match_map (
    input wire logic [1:0] map_i,
    input wire logic lo_match_i,
    input wire logic hi_match_i,
    input wire logic inside_i,
    output logic lo_chan_o,
    output logic hi_chan_o
);
    // reserved code falls through to inside range
    always_comb begin
        case (map_i)
            debug_arm_pkg::MAP_SINGLE: lo_chan_o = lo_match_i;
            debug_arm_pkg::MAP_OUTSIDE: lo_chan_o = !inside_i;
            default: lo_chan_o = inside_i;
        endcase
        hi_chan_o = (map_i == debug_arm_pkg::MAP_SINGLE) && hi_match_i;
    end
endmodule : pair_match_map

module debug_arm_trigger_control (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] cmp_match_i,
    input wire logic ab_inside_range_i,
    input wire logic cd_inside_range_i,
    input wire logic ext_event_i,
    input wire logic trace_enable_i,
    input wire logic trace_done_i,
    input wire logic profiling_active_i,
    input wire logic background_controller_i,
    input wire logic background_debug_state_i,
    output logic armed_o,
    output logic [2:0] seq_state_o,
    output logic [3:0] match_chan_o,
    output var debug_arm_pkg::break_req_s break_req_o,
    output logic trace_force_entry_o,
    output logic trace_gate_o
);
    debug_arm_pkg::ctl_one_s ctl_one_reg;
    debug_arm_pkg::ctl_two_s ctl_two_reg;
    debug_arm_pkg::seq_state_e state_reg, state_next;
    debug_arm_pkg::break_req_s break_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pslverr_reg;
    logic ext_sync1_reg, ext_sync2_reg, ext_prev_reg;
    logic [3:0] match_chan_reg;
    logic pend_reg, force_entry_reg, gate_reg;
    logic hit_one, hit_two, setup, wr_en, wr_one, wr_two;
    logic hw_disarm, sw_clear, force_req, ext_event, seq_hit, fire, open_cfg;
    logic [3:0] chan_next;
    logic [3:0] seq_chan;

    // bus decode; writes land only at the access edge with pready high
    assign hit_one = (paddr_i == debug_arm_pkg::CTL_ONE_ADDR);
    assign hit_two = (paddr_i == debug_arm_pkg::CTL_TWO_ADDR);
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pready_reg && pwrite_i;
    assign wr_one = wr_en && hit_one;
    assign wr_two = wr_en && hit_two;
    assign open_cfg = !ctl_one_reg.arm && !profiling_active_i;

    // sequencer side events
    assign hw_disarm = (state_reg == debug_arm_pkg::SEQ_FINAL);
    assign sw_clear = wr_one && ctl_one_reg.arm && !pwdata_i[debug_arm_pkg::ARM_POS]
        && !profiling_active_i;
    assign force_req = wr_one && pwdata_i[debug_arm_pkg::FORCE_POS];
    assign ext_event = ext_sync2_reg && !ext_prev_reg;

    // channel 3 can be replaced by the external event
    always_comb begin
        seq_chan = match_chan_reg;
        if (ctl_one_reg.external_event_select == debug_arm_pkg::EES_SEQ_INPUT) begin
            seq_chan[3] = ext_event;
        end
    end
    assign seq_hit = |seq_chan;

    // break goes out at once, or waits for the trace session to finish
    assign fire = (hw_disarm && ctl_one_reg.processor_break_enable && !trace_enable_i)
        || (pend_reg && trace_done_i);

    pair_match_map lower_map (
        .map_i(ctl_two_reg.lower_pair_match_map),
        .lo_match_i(cmp_match_i[0]),
        .hi_match_i(cmp_match_i[1]),
        .inside_i(ab_inside_range_i),
        .lo_chan_o(chan_next[0]),
        .hi_chan_o(chan_next[1])
    );

    pair_match_map upper_map (
        .map_i(ctl_two_reg.upper_pair_match_map),
        .lo_match_i(cmp_match_i[2]),
        .hi_match_i(cmp_match_i[3]),
        .inside_i(cd_inside_range_i),
        .lo_chan_o(chan_next[2]),
        .hi_chan_o(chan_next[3])
    );

    // two-flop synchroniser on the pin, third flop only for edge detect
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_sync1_reg <= ext_event_i;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // control register one
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ctl_one_reg <= debug_arm_pkg::ctl_one_s'({debug_arm_pkg::CTL_ONE_RESET[7],
                debug_arm_pkg::CTL_ONE_RESET[4:3], debug_arm_pkg::CTL_ONE_RESET[1:0]});
        end else begin
            if (hw_disarm) begin
                ctl_one_reg.arm <= 1'b0;
            end else if (wr_one && (pwdata_i[debug_arm_pkg::ARM_POS] || !profiling_active_i)) begin
                ctl_one_reg.arm <= pwdata_i[debug_arm_pkg::ARM_POS];
            end
            // old arm value gates, so a disarming write leaves these alone
            if (wr_one && open_cfg) begin
                ctl_one_reg.break_to_background <= pwdata_i[debug_arm_pkg::BTB_POS];
                ctl_one_reg.processor_break_enable <= pwdata_i[debug_arm_pkg::PBE_POS];
                ctl_one_reg.external_event_select <= pwdata_i[1:0];
            end
        end
    end

    // control register two
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ctl_two_reg <= debug_arm_pkg::ctl_two_s'(debug_arm_pkg::CTL_TWO_RESET[3:0]);
        end else if (wr_two && open_cfg) begin
            ctl_two_reg <= debug_arm_pkg::ctl_two_s'(pwdata_i[3:0]);
        end
    end

    // state sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            debug_arm_pkg::SEQ_IDLE: begin
                if (wr_one && pwdata_i[debug_arm_pkg::ARM_POS]) begin
                    state_next = force_req ? debug_arm_pkg::SEQ_FINAL
                                           : debug_arm_pkg::SEQ_FIRST;
                end
            end
            debug_arm_pkg::SEQ_FIRST: begin
                if (sw_clear) begin
                    state_next = debug_arm_pkg::SEQ_IDLE;
                end else if (force_req || seq_hit) begin
                    state_next = debug_arm_pkg::SEQ_FINAL;
                end
            end
            debug_arm_pkg::SEQ_FINAL: state_next = debug_arm_pkg::SEQ_IDLE;
            default: state_next = debug_arm_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_reg <= debug_arm_pkg::SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // deferred break; a new set wins over a trace-done in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= (hw_disarm && ctl_one_reg.processor_break_enable && trace_enable_i)
                || (pend_reg && !trace_done_i);
        end
    end

    // break routing; a suppressed break is dropped, not held
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            break_reg <= '0;
        end else begin
            break_reg.background <= fire && ctl_one_reg.break_to_background
                && background_controller_i;
            break_reg.software_interrupt_request <= fire && !ctl_one_reg.break_to_background
                && !background_debug_state_i;
        end
    end

    // match channels and trace controls
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            match_chan_reg <= 4'h0;
            force_entry_reg <= 1'b0;
            gate_reg <= 1'b0;
        end else begin
            match_chan_reg <= chan_next;
            force_entry_reg <= ext_event && trace_enable_i
                && (ctl_one_reg.external_event_select == debug_arm_pkg::EES_TRACE_ENTRY);
            gate_reg <= ext_sync2_reg
                && (ctl_one_reg.external_event_select == debug_arm_pkg::EES_GATE);
        end
    end

    // read data; force-final and reserved bits are zero
    always_comb begin
        prdata_next = 32'h0;
        if (hit_one) begin
            prdata_next[debug_arm_pkg::ARM_POS] = ctl_one_reg.arm;
            prdata_next[debug_arm_pkg::BTB_POS] = ctl_one_reg.break_to_background;
            prdata_next[debug_arm_pkg::PBE_POS] = ctl_one_reg.processor_break_enable;
            prdata_next[1:0] = ctl_one_reg.external_event_select;
        end else if (hit_two) begin
            prdata_next[3:0] = ctl_two_reg;
        end
    end

    // one wait-free access cycle: answer is prepared in setup so outputs stay registered
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit_one && !hit_two;
            prdata_reg <= (setup && !pwrite_i) ? prdata_next : 32'h0;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign armed_o = ctl_one_reg.arm;
    assign seq_state_o = state_reg;
    assign match_chan_o = match_chan_reg;
    assign break_req_o = break_reg;
    assign trace_force_entry_o = force_entry_reg;
    assign trace_gate_o = gate_reg;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_locked_fields;
        wr_one && ctl_one_reg.arm |=> $stable(ctl_one_reg[3:0]);
    endproperty
    a_locked_fields: assert property (p_locked_fields) else $error("low fields written while armed");

    property p_arm_held;
        wr_one && ctl_one_reg.arm && !pwdata_i[7] && profiling_active_i && !hw_disarm
            |=> ctl_one_reg.arm;
    endproperty
    a_arm_held: assert property (p_arm_held) else $error("arm cleared while profiling");

    property p_force_reads_zero;
        setup && hit_one && !pwrite_i |=> pready_reg && !prdata_reg[6];
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bit read one");

    property p_open_write;
        wr_one && open_cfg |=> ctl_one_reg.external_event_select == $past(pwdata_i[1:0]);
    endproperty
    a_open_write: assert property (p_open_write) else $error("low fields not written");

    property p_hw_wins;
        hw_disarm && wr_one && pwdata_i[7] |=> !ctl_one_reg.arm;
    endproperty
    a_hw_wins: assert property (p_hw_wins) else $error("write beat hardware disarm");

    property p_final_to_idle;
        state_reg == debug_arm_pkg::SEQ_FINAL |=> state_reg == debug_arm_pkg::SEQ_IDLE
            && !ctl_one_reg.arm;
    endproperty
    a_final_to_idle: assert property (p_final_to_idle) else $error("no auto disarm");

    property p_arm_first;
        wr_one && pwdata_i[7:6] == 2'h2 && state_reg == debug_arm_pkg::SEQ_IDLE
            |=> state_reg == debug_arm_pkg::SEQ_FIRST;
    endproperty
    a_arm_first: assert property (p_arm_first) else $error("arming missed first state");

    property p_quiet_disarm;
        sw_clear && state_reg == debug_arm_pkg::SEQ_FIRST && !pend_reg |-> ##2 break_reg == '0;
    endproperty
    a_quiet_disarm: assert property (p_quiet_disarm) else $error("break on software disarm");

    property p_force_final;
        force_req && state_reg == debug_arm_pkg::SEQ_FIRST && !sw_clear
            |=> state_reg == debug_arm_pkg::SEQ_FINAL;
    endproperty
    a_force_final: assert property (p_force_final) else $error("force did not reach final");

    property p_break_route;
        fire && ctl_one_reg.break_to_background |=> break_reg.background == $past(background_controller_i)
            && !break_reg.software_interrupt_request;
    endproperty
    a_break_route: assert property (p_break_route) else $error("background break misrouted");

    property p_break_defer;
        hw_disarm && ctl_one_reg.processor_break_enable && trace_enable_i
            |=> pend_reg && break_reg == '0;
    endproperty
    a_break_defer: assert property (p_break_defer) else $error("break not deferred");

    property p_two_locked;
        wr_two && !open_cfg |=> $stable(ctl_two_reg);
    endproperty
    a_two_locked: assert property (p_two_locked) else $error("register two written while locked");

    property p_range_disables;
        ctl_two_reg.upper_pair_match_map != debug_arm_pkg::MAP_SINGLE |=> !match_chan_reg[3];
    endproperty
    a_range_disables: assert property (p_range_disables) else $error("channel 3 not disabled");

    property p_reserved_inside;
        ctl_two_reg.lower_pair_match_map == debug_arm_pkg::MAP_RESERVED
            |=> match_chan_reg[0] == $past(ab_inside_range_i) && !match_chan_reg[1];
    endproperty
    a_reserved_inside: assert property (p_reserved_inside) else $error("reserved map not inside");

    c_arm_hit: cover property (state_reg == debug_arm_pkg::SEQ_FIRST && seq_hit);
    c_deferred_break: cover property (pend_reg && trace_done_i);
    c_swi: cover property (break_reg.software_interrupt_request);
    c_force: cover property (force_req && state_reg == debug_arm_pkg::SEQ_FIRST);
endmodule : debug_arm_trigger_control
`default_nettype wire

// *** tb_debug_arm_trigger_control.sv ***
`default_nettype none
module tb_debug_arm_trigger_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] a_one = debug_arm_pkg::CTL_ONE_ADDR;
    localparam logic [11:0] a_two = debug_arm_pkg::CTL_TWO_ADDR;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] cmp = 4'h0, chan;
    logic ab_in = 1'b0, cd_in = 1'b0, ext = 1'b0, trace_en = 1'b0, prof = 1'b0;
    logic bctl = 1'b0, bstate = 1'b0, pready, pslverr, trace_done, armed, tfe, tgate;
    logic [2:0] seq;
    debug_arm_pkg::break_req_s brk;
    int bg_n, swi_n;
    int n_mismatch = 0;
    int check_count = 0;
    // free running bus clock
    always #2.5 clk = ~clk;
    debug_arm_trigger_control u_debug_arm_trigger_control (
        .ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmp_match_i(cmp),
        .ab_inside_range_i(ab_in), .cd_inside_range_i(cd_in), .ext_event_i(ext),
        .trace_enable_i(trace_en), .trace_done_i(trace_done),
        .profiling_active_i(prof), .background_controller_i(bctl),
        .background_debug_state_i(bstate), .armed_o(armed), .seq_state_o(seq),
        .match_chan_o(chan), .break_req_o(brk), .trace_force_entry_o(tfe),
        .trace_gate_o(tgate)
    );
    debug_arm_core_model u_debug_arm_core_model (
        .ref_clk_i(clk), .rstn_i(rstn), .break_req_i(brk), .trace_enable_i(trace_en),
        .armed_i(armed), .trace_done_o(trace_done), .bg_count_o(bg_n), .swi_count_o(swi_n)
    );
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // a bounded wait that ran out ends the run at once
    task automatic timeout(input string what);
        n_mismatch++;
        $display("unexpected %s: wait ran out", what);
        finish_test();
    endtask : timeout
    // let the edge's updates land before looking
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : look
    // setup, then access held until pready is sampled high, released at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) timeout("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 8'h00, rd, err);
        check(what, rd, {24'h0, exp});
        check("pslverr", 32'(err), 32'h0);
    endtask : rd_chk
    task automatic wait_disarm();
        int n = 0;
        // first look after the edge, so an arm still landing is not missed
        do begin
            look(1);
            n++;
        end while (armed !== 1'b0 && n < 40);
        if (armed !== 1'b0) timeout("disarm");
    endtask : wait_disarm
    // expected channel pair for one comparator pair
    function automatic logic [1:0] mexp(input logic [1:0] c, input logic hi, input logic lo,
                                        input logic in);
        case (c)
            2'h0: return {hi, lo};
            2'h2: return {1'b0, !in};
            default: return {1'b0, in};
        endcase
    endfunction : mexp
    // session forced to final at arming; routing judged by the break counts
    task automatic brk_case(input logic [5:0] low, input logic bc, input logic bs,
                            input int dbg, input int dswi);
        int b0 = bg_n;
        int s0 = swi_n;
        @(posedge clk);
        bctl <= bc;
        bstate <= bs;
        wr(a_one, {2'b11, low});
        wait_disarm();
        look(3);
        check("bg breaks", 32'(bg_n - b0), 32'(dbg));
        check("swi breaks", 32'(swi_n - s0), 32'(dswi));
    endtask : brk_case
    // reset, then the scenarios in order
    initial begin
        logic [31:0] rd;
        logic err;
        logic got;
        logic [1:0] c;
        int s0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        look(1);
        check("idle state", 32'(seq), 32'h1);
        rd_chk("ctl one reset", a_one, 8'h00);
        rd_chk("ctl two reset", a_two, 8'h00);
        apb(1'b0, 12'h408, 8'h00, rd, err);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        wr(a_one, 8'h7f);
        #1;
        check("force while idle", 32'(seq), 32'h1);
        rd_chk("ctl one fields", a_one, 8'h1b);
        wr(a_one, 8'h08);
        wr(a_two, 8'hff);
        rd_chk("ctl two fields", a_two, 8'h0f);
        // every map code, with distinct patterns so swapped channels show
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(a_two, {4'h0, c, c});
            for (int s = 0; s < 2; s++) begin
                @(posedge clk);
                cmp <= (s == 0) ? 4'h5 : 4'ha;
                ab_in <= s[0];
                cd_in <= !s[0];
                look(3);
                check("match channels", 32'(chan), 32'({mexp(c, cmp[3], cmp[2], cd_in),
                    mexp(c, cmp[1], cmp[0], ab_in)}));
            end
        end
        wr(a_two, 8'h00);
        cmp <= 4'h0;
        s0 = swi_n;
        wr(a_one, 8'h88);
        look(1);
        check("armed state", 32'(seq), 32'h2);
        wr(a_one, 8'h93);
        rd_chk("ctl one armed", a_one, 8'h88);
        wr(a_two, 8'h0f);
        rd_chk("ctl two armed", a_two, 8'h00);
        prof <= 1'b1;
        wr(a_one, 8'h08);
        rd_chk("clear under profiling", a_one, 8'h88);
        prof <= 1'b0;
        cmp <= 4'h1;
        // the hit lands final on the setup edge of this write, one edge before its access edge
        wr(a_one, 8'h88);
        wait_disarm();
        @(posedge clk);
        cmp <= 4'h0;
        look(3);
        check("end state", 32'(seq), 32'h1);
        check("swi on end", 32'(swi_n - s0), 32'h1);
        wr(a_one, 8'h88);
        wr(a_one, 8'h00);
        look(3);
        check("armed after clear", 32'(armed), 32'h0);
        check("swi on clear", 32'(swi_n - s0), 32'h1);
        rd_chk("low bits kept", a_one, 8'h08);
        wr(a_one, 8'h00);
        rd_chk("second write", a_one, 8'h00);
        brk_case(6'h18, 1'b1, 1'b0, 1, 0);
        brk_case(6'h18, 1'b0, 1'b0, 0, 0);
        brk_case(6'h08, 1'b0, 1'b0, 0, 1);
        brk_case(6'h08, 1'b1, 1'b1, 0, 0);
        brk_case(6'h00, 1'b1, 1'b0, 0, 0);
        @(posedge clk);
        trace_en <= 1'b1;
        s0 = swi_n;
        wr(a_one, 8'h88);
        wr(a_one, 8'hc8);
        wait_disarm();
        look(2);
        check("break held for trace", 32'(swi_n - s0), 32'h0);
        look(12);
        check("break after trace", 32'(swi_n - s0), 32'h1);
        wr(a_one, 8'h01);
        ext <= 1'b1;
        got = 1'b0;
        repeat (8) begin
            look(1);
            if (tfe === 1'b1) got = 1'b1;
        end
        check("trace entry", 32'(got), 32'h1);
        @(posedge clk);
        ext <= 1'b0;
        trace_en <= 1'b0;
        wr(a_one, 8'h03);
        ext <= 1'b1;
        look(5);
        check("trace gate on", 32'(tgate), 32'h1);
        @(posedge clk);
        ext <= 1'b0;
        look(5);
        check("trace gate off", 32'(tgate), 32'h0);
        s0 = swi_n;
        wr(a_one, 8'h8a);
        ext <= 1'b1;
        wait_disarm();
        look(2);
        check("event ends session", 32'(armed), 32'h0);
        check("event break", 32'(swi_n - s0), 32'h1);
        finish_test();
    end
endmodule : tb_debug_arm_trigger_control
`default_nettype wire
